// file: core/dpc_consts.vh
// Constants for the dual preset counter mode logic
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH
`define DPC_CNT_W 16
`define DPC_TIME_W 14
`define DPC_COUNT_RST 16'h0000
`define DPC_TIMER_RST 14'h0000
`define DPC_TICK_MS 10
`define DPC_CLK_NS 10
`define DPC_TICK_CYCLES ((`DPC_TICK_MS * 1000000) / `DPC_CLK_NS)
`define DPC_TICKDIV_W 20
`define DPC_MODE_MSB 3
`define DPC_MODE_RTP_BIT 3
`define DPC_MODE_TIMED1_BIT 0
`define DPC_MODE_AUTO_BIT 2
`define DPC_MODE_AFTER_BIT 1
`define DPC_MODE_4 4'h4
`define DPC_MODE_5 4'h5
`define DPC_MODE_6 4'h6
`define DPC_MODE_7 4'h7
`define DPC_MODE_8 4'h8
`define DPC_MODE_9 4'h9
`define DPC_MODE_10 4'ha
`define DPC_MODE_11 4'hb
`define DPC_MODE_12 4'hc
`define DPC_MODE_13 4'hd
`define DPC_MODE_14 4'he
`define DPC_MODE_15 4'hf
`endif

// file: core/dpc_counter.v
// Dual preset pulse counter with mode controlled outputs
// Notes on behaviour
// - Mode 4: out1 on at preset1; at preset2 out2 timed, out1 off, reload zero.
// - Mode 5: both outputs timed independently; reload zero at preset2.
// - Mode 6: out1 on at preset1, off at preset2; reload zero when out2 ends.
// - Mode 7: both timed; reload zero when out2 timing finishes.
// - Mode 8: count down; latch out1 at preset1, out2 at zero; keep counting.
// - Mode 9: count down; timed out1 at preset1, out2 at zero; keep counting.
// - Mode 10: out1 on at preset1; at zero out2 latches, out1 off.
// - Mode 11: out1 on at preset1; at zero out1 off, timed out2.
// - Mode 12: at zero timed out2, out1 off, reload preset2 at once.
// - Mode 13: both timed; reload preset2 at zero.
// - Mode 14: at zero out1 off, timed out2; reload preset2 when out2 ends.
// - Mode 15: both timed; reload preset2 when out2 ends.
// - Automatic reloads never drop a count pulse arriving in that cycle.
// - Manual reset wins always, reloads start value, drops both outputs.
// - Manual reset comes from remote terminal always, front button when enabled.
// - Front reset enable switch gates the front panel button.
// - Switches 5 to 8 choose the mode; 1 to 3 only condition input.
// - Count up when direction high, down when low, in any mode.
// - Remote reset held low holds counter reset with outputs off.
// - Each falling edge of the count input registers one count.
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_counter
(
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Field terminals
    input wire count_n_i,
    input wire count_direction_input_i,
    input wire remote_reset_n_i,
    input wire front_reset_button_i,
    // Rear switches
    input wire front_reset_enable_switch_i,
    input wire mode_sw5_i,
    input wire mode_sw6_i,
    input wire mode_sw7_i,
    input wire mode_sw8_i,
    // Programmed values
    input wire [`DPC_CNT_W-1:0] preset1_i,
    input wire [`DPC_CNT_W-1:0] preset2_i,
    input wire [`DPC_TIME_W-1:0] time1_i,
    input wire [`DPC_TIME_W-1:0] time2_i,
    // Results
    output reg [`DPC_CNT_W-1:0] count_o,
    output reg output1_o,
    output reg output2_o,
    output reg [3:0] mode_o
);
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg count_prev;
    reg [`DPC_TICKDIV_W-1:0] tick_div;
    reg tick;
    reg latch1;
    reg latch2;
    reg [`DPC_CNT_W-1:0] next_count;
    reg next_latch1;
    reg next_latch2;
    reg fire1;
    reg fire2;
    reg [`DPC_CNT_W-1:0] stepped;
    reg [`DPC_CNT_W-1:0] start_val;
    wire [3:0] mode;
    reg armed;
    reg rtp;
    reg timed1;
    reg latch2_mode;
    reg clear1;
    reg auto_rl;
    reg after_t2;
    wire manual_rst;
    wire count_pulse;
    wire t1_active;
    wire t2_active;
    wire t2_expire;
    wire hit1;
    wire hit2;

    assign mode = {mode_sw5_i, mode_sw6_i, mode_sw7_i, mode_sw8_i};

    // Per mode output and reload behaviour
    always @*
    begin
        armed = 1'b1;
        rtp = 1'b0;
        timed1 = 1'b0;
        latch2_mode = 1'b0;
        clear1 = 1'b0;
        auto_rl = 1'b0;
        after_t2 = 1'b0;
        case (mode)
            `DPC_MODE_4:
            begin
                clear1 = 1'b1;
                auto_rl = 1'b1;
            end
            `DPC_MODE_5:
            begin
                timed1 = 1'b1;
                auto_rl = 1'b1;
            end
            `DPC_MODE_6:
            begin
                clear1 = 1'b1;
                auto_rl = 1'b1;
                after_t2 = 1'b1;
            end
            `DPC_MODE_7:
            begin
                timed1 = 1'b1;
                auto_rl = 1'b1;
                after_t2 = 1'b1;
            end
            `DPC_MODE_8:
            begin
                rtp = 1'b1;
                latch2_mode = 1'b1;
            end
            `DPC_MODE_9:
            begin
                rtp = 1'b1;
                timed1 = 1'b1;
            end
            `DPC_MODE_10:
            begin
                rtp = 1'b1;
                latch2_mode = 1'b1;
                clear1 = 1'b1;
            end
            `DPC_MODE_11:
            begin
                rtp = 1'b1;
                clear1 = 1'b1;
            end
            `DPC_MODE_12:
            begin
                rtp = 1'b1;
                clear1 = 1'b1;
                auto_rl = 1'b1;
            end
            `DPC_MODE_13:
            begin
                rtp = 1'b1;
                timed1 = 1'b1;
                auto_rl = 1'b1;
            end
            `DPC_MODE_14:
            begin
                rtp = 1'b1;
                clear1 = 1'b1;
                auto_rl = 1'b1;
                after_t2 = 1'b1;
            end
            `DPC_MODE_15:
            begin
                rtp = 1'b1;
                timed1 = 1'b1;
                auto_rl = 1'b1;
                after_t2 = 1'b1;
            end
            default:
            begin
                // Unhandled modes only count
                armed = 1'b0;
            end
        endcase
    end

    // Remote always, front only when enabled
    assign manual_rst = !remote_reset_n_i ||
        (front_reset_enable_switch_i && front_reset_button_i);
    assign count_pulse = count_prev && !count_n_i;

    // Detect targets on the value the next count reaches
    assign hit1 = count_pulse && armed && (stepped == preset1_i);
    assign hit2 = count_pulse && armed && (stepped == (rtp ? `DPC_COUNT_RST : preset2_i));

    always @*
    begin
        start_val = rtp ? preset2_i : `DPC_COUNT_RST;
        stepped = count_direction_input_i ? count_o + 16'h0001 : count_o - 16'h0001;
        next_count = count_o;
        next_latch1 = latch1;
        next_latch2 = latch2;
        next_state = state;
        fire1 = 1'b0;
        fire2 = 1'b0;
        if (count_pulse)
        begin
            next_count = stepped;
        end
        case (state)
            ST_RUN:
            begin
                if (hit1)
                begin
                    fire1 = timed1;
                    next_latch1 = !timed1;
                end
                if (hit2)
                begin
                    fire2 = !latch2_mode;
                    next_latch2 = latch2_mode;
                    if (clear1)
                    begin
                        next_latch1 = 1'b0;
                    end
                    if (auto_rl && !after_t2)
                    begin
                        // Reload lands on the hit value, so no pulse is lost
                        next_count = start_val;
                    end
                    else if (auto_rl)
                    begin
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (t2_expire)
                begin
                    // Pulse of this cycle is folded into the reloaded value
                    if (count_pulse)
                    begin
                        next_count = count_direction_input_i ?
                            start_val + 16'h0001 : start_val - 16'h0001;
                    end
                    else
                    begin
                        next_count = start_val;
                    end
                    next_state = ST_RUN;
                end
            end
            default:
            begin
                next_state = ST_RUN;
            end
        endcase
        if (manual_rst)
        begin
            next_count = start_val;
            next_latch1 = 1'b0;
            next_latch2 = 1'b0;
            next_state = ST_RUN;
        end
    end

    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_RUN;
            count_prev <= 1'b1;
            tick_div <= 20'h00000;
            tick <= 1'b0;
            latch1 <= 1'b0;
            latch2 <= 1'b0;
            count_o <= `DPC_COUNT_RST;
            output1_o <= 1'b0;
            output2_o <= 1'b0;
            mode_o <= 4'h0;
        end
        else
        begin
            count_prev <= count_n_i;
            if (tick_div == `DPC_TICK_CYCLES - 1)
            begin
                tick_div <= 20'h00000;
                tick <= 1'b1;
            end
            else
            begin
                tick_div <= tick_div + 20'h00001;
                tick <= 1'b0;
            end
            state <= next_state;
            latch1 <= next_latch1;
            latch2 <= next_latch2;
            count_o <= next_count;
            // Timed outputs rise on the same edge as the count that fires them
            output1_o <= !manual_rst && (next_latch1 || fire1 || t1_active);
            output2_o <= !manual_rst && (next_latch2 || fire2 || t2_active);
            mode_o <= mode;
        end
    end

    dpc_out_timer u_timer1
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .fire_i(fire1),
        .kill_i(manual_rst),
        .duration_i(time1_i),
        .active_o(t1_active),
        .expire_o()
    );

    dpc_out_timer u_timer2
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .fire_i(fire2),
        .kill_i(manual_rst),
        .duration_i(time2_i),
        .active_o(t2_active),
        .expire_o(t2_expire)
    );
endmodule

// file: core/dpc_out_timer.v
// Down-counting timer for one timed output
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_out_timer
(
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Control
    input wire tick_i,
    input wire fire_i,
    input wire kill_i,
    input wire [`DPC_TIME_W-1:0] duration_i,
    // Status
    output reg active_o,
    output reg expire_o
);
    reg [`DPC_TIME_W-1:0] remain;
    always @(posedge clock_i)
    begin
        if (!rst_n_i || kill_i)
        begin
            remain <= `DPC_TIMER_RST;
            active_o <= 1'b0;
            expire_o <= 1'b0;
        end
        else if (fire_i)
        begin
            // Zero duration gives a one tick pulse
            remain <= (duration_i == `DPC_TIMER_RST) ? 14'h0001 : duration_i;
            active_o <= 1'b1;
            expire_o <= 1'b0;
        end
        else if (active_o && tick_i)
        begin
            remain <= remain - 14'h0001;
            if (remain == 14'h0001)
            begin
                active_o <= 1'b0;
                expire_o <= 1'b1;
            end
            else
            begin
                expire_o <= 1'b0;
            end
        end
        else
        begin
            expire_o <= 1'b0;
        end
    end
endmodule

// file: verification/dpc_counter_monitor.sv
// Checker for the dual preset counter ports
`timescale 1ns/1ps
module dpc_counter_monitor
(
    // Watched ports
    input wire clock_i,
    input wire rst_n_i,
    input wire count_n_i,
    input wire count_direction_input_i,
    input wire remote_reset_n_i,
    input wire front_reset_button_i,
    input wire front_reset_enable_switch_i,
    input wire mode_sw5_i,
    input wire [15:0] preset1_i,
    input wire [15:0] preset2_i,
    input wire [15:0] count_o,
    input wire output1_o,
    input wire output2_o,
    input wire [3:0] mode_o
);
    wire man = !remote_reset_n_i || (front_reset_button_i && front_reset_enable_switch_i);
    wire up = !man && count_direction_input_i;
    wire dn = !man && !count_direction_input_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_off; man |=> !output1_o && !output2_o; endproperty
    a_off: assert property (p_off) else $error("outputs on");
    property p_load;
        man && mode_sw5_i == mode_o[3] |=> count_o == (mode_o[3] ? $past(preset2_i) : 16'h0);
    endproperty
    a_load: assert property (p_load) else $error("bad start");
    property p_front;
        front_reset_button_i && !front_reset_enable_switch_i && remote_reset_n_i && count_n_i
            && !mode_o[1] |=> $stable(count_o);
    endproperty
    a_front: assert property (p_front) else $error("front");
    property p_dn;
        $fell(count_n_i) && dn && mode_o[3:2] == 2'b10 |=> count_o == $past(count_o) - 16'h1;
    endproperty
    a_dn: assert property (p_dn) else $error("down");
    property p_up;
        $fell(count_n_i) && up && mode_o[3:2] == 2'b10 |=> count_o == $past(count_o) + 16'h1;
    endproperty
    a_up: assert property (p_up) else $error("up");
    property p_p1;
        $fell(count_n_i) && dn && mode_o[3] && count_o == preset1_i + 16'h1 |=> output1_o;
    endproperty
    a_p1: assert property (p_p1) else $error("out1");
    property p_wu;
        $fell(count_n_i) && up && mode_o[3:1] == 3'b010 && count_o + 16'h1 == preset2_i
            |=> count_o == 16'h0 && output2_o && (mode_o[0] || !output1_o);
    endproperty
    a_wu: assert property (p_wu) else $error("wrap up");
    property p_wd;
        $fell(count_n_i) && dn && mode_o[3:1] == 3'b110 && count_o == 16'h1
            |=> count_o == $past(preset2_i) && output2_o;
    endproperty
    a_wd: assert property (p_wd) else $error("wrap down");
endmodule
bind dpc_counter dpc_counter_monitor i_dpc_counter_monitor (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .count_n_i(count_n_i), .count_direction_input_i(count_direction_input_i),
    .remote_reset_n_i(remote_reset_n_i), .front_reset_button_i(front_reset_button_i),
    .front_reset_enable_switch_i(front_reset_enable_switch_i), .mode_sw5_i(mode_sw5_i),
    .preset1_i(preset1_i), .preset2_i(preset2_i), .count_o(count_o), .output1_o(output1_o),
    .output2_o(output2_o), .mode_o(mode_o));

// file: verification/dpc_counter_tb_top.sv
// Testbench for the dual preset counter mode logic
`timescale 1ns/1ps
module dpc_counter_tb_top;
    reg clock_i = 1'b0, rst_n_i = 1'b0, sense = 1'b0, dir = 1'b1, rem_n = 1'b1;
    reg front = 1'b0, en = 1'b0, e1 = 1'b0, e2 = 1'b0;
    reg [3:0] mode = 4'h4;
    reg [15:0] p1 = 16'h1, p2 = 16'h2, ec = 16'h0;
    reg [13:0] t1 = 14'h10, t2 = 14'h10;
    reg [21:0] got;
    reg [21:0] exp_q[$];
    wire cnt_n, o1, o2;
    wire [15:0] cnt;
    wire [3:0] mo;
    integer seed = 50, r, m, i, err_total = 0, checked = 0;
    event ev_chk;
    always #5 clock_i = ~clock_i;
    dpc_sensor_model i_dpc_sensor_model (.clock_i(clock_i), .sense_i(sense), .count_n_o(cnt_n));
    dpc_counter i_dpc_counter (.clock_i(clock_i), .rst_n_i(rst_n_i), .count_n_i(cnt_n),
        .count_direction_input_i(dir), .remote_reset_n_i(rem_n), .front_reset_button_i(front),
        .front_reset_enable_switch_i(en), .mode_sw5_i(mode[3]), .mode_sw6_i(mode[2]),
        .mode_sw7_i(mode[1]), .mode_sw8_i(mode[0]), .preset1_i(p1), .preset2_i(p2),
        .time1_i(t1), .time2_i(t2), .count_o(cnt), .output1_o(o1), .output2_o(o2), .mode_o(mo));
    task note;
        begin
            exp_q.push_back({mode, ec, e1, e2});
            -> ev_chk;
        end
    endtask
    task start;
        begin
            ec = mode[3] ? p2 : 16'h0;
            e1 = 1'b0;
            e2 = 1'b0;
        end
    endtask
    // One count pulse, then model the step
    task pulse(input reg live);
        begin
            sense = 1'b1;
            @(negedge clock_i);
            sense = 1'b0;
            repeat (2) @(negedge clock_i);
            if (live)
            begin
                ec = dir ? ec + 16'h1 : ec - 16'h1;
                if (ec == p1) e1 = 1'b1;
                if (mode[3] ? ec == 16'h0 : ec == p2)
                begin
                    e2 = 1'b1;
                    if ((!mode[0] && mode != 4'h8) || mode == 4'hb) e1 = 1'b0;
                    if (mode[2:1] == 2'b10) ec = mode[3] ? p2 : 16'h0;
                end
            end
            note;
        end
    endtask
    always @(ev_chk)
    begin
        checked = checked + 1;
        got = exp_q.pop_front();
        if ({mo, cnt, o1, o2} !== got)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: got %h want %h", $time, {mo, cnt, o1, o2}, got);
        end
    end
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        repeat (20) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        note;
        for (m = 4; m < 16; m = m + 1)
        begin
            r = $random(seed);
            rem_n = 1'b0;
            mode = m[3:0];
            dir = !mode[3];
            p1 = 16'h1 + {14'h0, r[1:0]};
            p2 = p1 + 16'h1 + {14'h0, r[3:2]};
            t1 = 14'h10 + {10'h0, r[7:4]};
            t2 = 14'h10 + {10'h0, r[11:8]};
            @(negedge clock_i);
            start;
            pulse(1'b0);
            rem_n = 1'b1;
            for (i = 0; i <= p2; i = i + 1)
                pulse(1'b1);
            if (mode[3:2] == 2'b10)
            begin
                dir = 1'b1;
                pulse(1'b1);
            end
            front = 1'b1;
            repeat (2) @(negedge clock_i);
            note;
            en = 1'b1;
            repeat (2) @(negedge clock_i);
            start;
            note;
            front = 1'b0;
            en = 1'b0;
        end
        final_report;
    end
    initial
    begin
        #200000;
        err_total = err_total + 1;
        final_report;
    end
endmodule

// file: verification/dpc_sensor_model.sv
// Pulse sensor model pulling the count line low
`timescale 1ns/1ps
module dpc_sensor_model
(
    // Clock and request
    input wire clock_i,
    input wire sense_i,
    // Count line, pulled up when idle
    output reg count_n_o
);
    initial count_n_o = 1'b1;
    always @(posedge clock_i)
    begin
        count_n_o <= ~sense_i;
    end
endmodule
